//--- src/fifo_port_config.v
// Bus-matching FIFO with strap configuration, offset registers and flags.
// Assumes straps and data pins synchronous to core_clk; straps held
// steady by the surrounding logic once master reset has ended.
// Summary of operation
// - Width strap pair and match strap choose write and read port widths.
// - Straps are latched during master reset; later levels are ignored.
// - Byte-order strap low selects big-endian, high selects little-endian.
// - Narrow write port ignores unused upper data input lines.
// - Empty output shows memory empty, or output data valid in fall-through.
// - Full output shows memory full, or space remaining in fall-through.
// - Two select straps plus load level pick one of eight default offsets.
// - Fall-through pin picks timing mode in reset, later is serial input.
// - Half-full output shows stored word count above half capacity.
// - Parity strap low picks non-interspersed, high picks interspersed.
// - Parity placement only affects parallel offset loading, not data.
// - Load level during master reset picks serial or parallel programming.
// - Load enable after reset steers writes and reads to offset registers.
// - Interspersed parity skips bits 8, 17, 26 and 35 in offset loads.
// - Big-endian reads most significant piece first, little-endian least.
`timescale 1ns/1ps
`include "fifo_port_regs.vh"
module fifo_port_config #(
  parameter AW = 4,
  parameter DEPTH = 16,
  parameter OFS_W = 5
) (
  input wire core_clk,
  input wire rst,
  input wire master_reset_n,
  input wire width_match_select,
  input wire write_width_select,
  input wire read_width_select,
  input wire byte_order_select,
  input wire parity_placement_select,
  input wire default_offset_select_0,
  input wire default_offset_select_1,
  input wire fall_through_select,
  input wire offset_access_enable,
  input wire serial_load_en,
  input wire write_en,
  input wire [35:0] write_data_in,
  input wire read_en,
  output reg [35:0] read_data_out,
  output reg empty_indicator,
  output reg full_indicator,
  output reg half_full_indicator,
  output reg almost_empty_indicator,
  output reg almost_full_indicator
);
  reg [7:0] cfg_r;
  reg [OFS_W-1:0] offset_empty_r;
  reg [OFS_W-1:0] offset_full_r;
  reg wr_ofs_sel_r;
  reg rd_ofs_sel_r;
  reg [OFS_W-1:0] serial_cnt_r;
  reg [35:0] asm_r;
  reg [2:0] wr_cnt_r;
  reg [35:0] hold_r;
  reg [2:0] pieces_left_r;
  reg out_valid_r;
  reg [3:0] width_nxt;
  reg [7:0] default_wide;
  reg [2:0] wr_last;
  reg [2:0] rd_last;
  reg [35:0] asm_nxt;
  reg [35:0] piece_src;
  wire in_master_reset;
  wire little_end;
  wire fall_through_select_mode;
  wire [1:0] wr_width;
  wire [1:0] rd_width;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [35:0] fifo_out_data;
  wire [AW:0] fifo_count;
  wire [AW:0] free_count;
  wire data_access;
  wire wr_accept;
  wire wr_last_piece;
  wire avail;
  wire advance;
  wire from_fifo;
  wire [31:0] ofs_word;
  wire [OFS_W-1:0] default_nxt;
  localparam [7:0] OFS_RST_WIDE = `DEF_OFS_0;

  assign in_master_reset = !master_reset_n;
  assign little_end = cfg_r[`CFG_BYTE_ORDER];
  assign fall_through_select_mode = cfg_r[`CFG_FALL_THROUGH];
  assign wr_width = cfg_r[`CFG_WR_WIDTH+1:`CFG_WR_WIDTH];
  assign rd_width = cfg_r[`CFG_RD_WIDTH+1:`CFG_RD_WIDTH];
  assign free_count = DEPTH[AW:0] - fifo_count;

  // Write width in [3:2] and read width in [1:0]; decoded from straps
  always @* begin
    width_nxt = {`PORT_W36, `PORT_W36};
    if (width_match_select) begin
      case ({write_width_select, read_width_select})
        2'b00: width_nxt = {`PORT_W36, `PORT_W18};
        2'b01: width_nxt = {`PORT_W36, `PORT_W9};
        2'b10: width_nxt = {`PORT_W18, `PORT_W36};
        default: width_nxt = {`PORT_W9, `PORT_W36};
      endcase
    end
  end

  always @* begin
    case ({offset_access_enable, default_offset_select_1, default_offset_select_0})
      3'h0: default_wide = `DEF_OFS_0;
      3'h1: default_wide = `DEF_OFS_1;
      3'h2: default_wide = `DEF_OFS_2;
      3'h3: default_wide = `DEF_OFS_3;
      3'h4: default_wide = `DEF_OFS_4;
      3'h5: default_wide = `DEF_OFS_5;
      3'h6: default_wide = `DEF_OFS_6;
      default: default_wide = `DEF_OFS_7;
    endcase
  end
  // Offsets keep only the low OFS_W bits
  assign default_nxt = default_wide[OFS_W-1:0];

  // straps caught on every core_clk edge during master reset, frozen after
  always @(posedge core_clk) begin
    if (rst) begin
      cfg_r <= `CFG_RESET;
    end else if (in_master_reset) begin
      cfg_r[`CFG_BYTE_ORDER] <= byte_order_select;
      cfg_r[`CFG_FALL_THROUGH] <= fall_through_select;
      cfg_r[`CFG_PARITY] <= parity_placement_select;
      cfg_r[`CFG_SERIAL] <= offset_access_enable;
      cfg_r[`CFG_WR_WIDTH+1:`CFG_RD_WIDTH] <= width_nxt;
    end
  end

  always @* begin
    case (wr_width)
      `PORT_W18: wr_last = `LAST_PIECE_18;
      `PORT_W9: wr_last = `LAST_PIECE_9;
      default: wr_last = `LAST_PIECE_36;
    endcase
    case (rd_width)
      `PORT_W18: rd_last = `LAST_PIECE_18;
      `PORT_W9: rd_last = `LAST_PIECE_9;
      default: rd_last = `LAST_PIECE_36;
    endcase
  end

  // load enable diverts both ports to the offset registers
  assign data_access = master_reset_n && !offset_access_enable;
  assign wr_last_piece = (wr_cnt_r == wr_last);
  assign wr_accept = data_access && write_en && (!wr_last_piece || fifo_in_ready);

  // narrow write pieces masked; placement by byte order
  always @* begin
    asm_nxt = asm_r;
    case (wr_width)
      `PORT_W18: begin
        if (little_end) begin
          asm_nxt = {write_data_in[17:0], asm_r[35:18]};
        end else begin
          asm_nxt = {asm_r[17:0], write_data_in[17:0]};
        end
      end
      `PORT_W9: begin
        if (little_end) begin
          asm_nxt = {write_data_in[8:0], asm_r[35:9]};
        end else begin
          asm_nxt = {asm_r[26:0], write_data_in[8:0]};
        end
      end
      default: asm_nxt = write_data_in;
    endcase
  end

  always @(posedge core_clk) begin
    if (rst || in_master_reset) begin
      asm_r <= 36'h000000000;
      wr_cnt_r <= 3'h0;
    end else if (wr_accept) begin
      asm_r <= asm_nxt;
      wr_cnt_r <= wr_last_piece ? 3'h0 : wr_cnt_r + 3'h1;
    end
  end

  // data words stored untouched by parity placement
  word_fifo #(
    .W(36),
    .AW(AW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rst(rst),
    .flush(in_master_reset),
    .in_valid(wr_accept && wr_last_piece),
    .in_ready(fifo_in_ready),
    .in_data(asm_nxt),
    .out_valid(fifo_out_valid),
    .out_ready(advance && from_fifo),
    .out_data(fifo_out_data),
    .count(fifo_count)
  );

  // parity positions dropped in interspersed mode
  assign ofs_word = cfg_r[`CFG_PARITY] ?
    {write_data_in[34:27], write_data_in[25:18], write_data_in[16:9], write_data_in[7:0]} :
    write_data_in[31:0];

  // offset register load, serial or parallel by latched method
  always @(posedge core_clk) begin
    if (rst) begin
      offset_empty_r <= OFS_RST_WIDE[OFS_W-1:0];
      offset_full_r <= OFS_RST_WIDE[OFS_W-1:0];
      wr_ofs_sel_r <= 1'b0;
      serial_cnt_r <= {OFS_W{1'b0}};
    end else if (in_master_reset) begin
      offset_empty_r <= default_nxt;
      offset_full_r <= default_nxt;
      wr_ofs_sel_r <= 1'b0;
      serial_cnt_r <= {OFS_W{1'b0}};
    end else if (offset_access_enable) begin
      if (cfg_r[`CFG_SERIAL] && serial_load_en) begin
        // shared pin is the serial data input after reset
        if (wr_ofs_sel_r) begin
          offset_full_r <= {fall_through_select, offset_full_r[OFS_W-1:1]};
        end else begin
          offset_empty_r <= {fall_through_select, offset_empty_r[OFS_W-1:1]};
        end
        if (serial_cnt_r == OFS_W - 1) begin
          serial_cnt_r <= {OFS_W{1'b0}};
          wr_ofs_sel_r <= !wr_ofs_sel_r;
        end else begin
          serial_cnt_r <= serial_cnt_r + {{(OFS_W-1){1'b0}}, 1'b1};
        end
      end else if (!cfg_r[`CFG_SERIAL] && write_en) begin
        if (wr_ofs_sel_r) begin
          offset_full_r <= ofs_word[OFS_W-1:0];
        end else begin
          offset_empty_r <= ofs_word[OFS_W-1:0];
        end
        wr_ofs_sel_r <= !wr_ofs_sel_r;
      end
    end
  end

  // Read side: split stored words into read-width pieces
  assign avail = (pieces_left_r != 3'h0) || fifo_out_valid;
  assign from_fifo = (pieces_left_r == 3'h0);
  // standard mode reads on request, fall-through refills output
  assign advance = data_access && avail &&
    (fall_through_select_mode ? (!out_valid_r || read_en) : read_en);

  always @* begin
    piece_src = from_fifo ? fifo_out_data : hold_r;
  end

  always @(posedge core_clk) begin
    if (rst || in_master_reset) begin
      read_data_out <= 36'h000000000;
      hold_r <= 36'h000000000;
      pieces_left_r <= 3'h0;
      out_valid_r <= 1'b0;
      rd_ofs_sel_r <= 1'b0;
    end else if (offset_access_enable) begin
      if (read_en) begin
        read_data_out <= rd_ofs_sel_r ? {{(36-OFS_W){1'b0}}, offset_full_r} :
          {{(36-OFS_W){1'b0}}, offset_empty_r};
        rd_ofs_sel_r <= !rd_ofs_sel_r;
      end
    end else if (advance) begin
      out_valid_r <= 1'b1;
      pieces_left_r <= from_fifo ? rd_last : pieces_left_r - 3'h1;
      case (rd_width)
        `PORT_W18: begin
          if (little_end) begin
            read_data_out <= {18'h00000, piece_src[17:0]};
            hold_r <= {18'h00000, piece_src[35:18]};
          end else begin
            read_data_out <= {18'h00000, piece_src[35:18]};
            hold_r <= {piece_src[17:0], 18'h00000};
          end
        end
        `PORT_W9: begin
          if (little_end) begin
            read_data_out <= {27'h0000000, piece_src[8:0]};
            hold_r <= {9'h000, piece_src[35:9]};
          end else begin
            read_data_out <= {27'h0000000, piece_src[35:27]};
            hold_r <= {piece_src[26:0], 9'h000};
          end
        end
        default: begin
          read_data_out <= piece_src;
          hold_r <= piece_src;
        end
      endcase
    end else if (fall_through_select_mode && read_en) begin
      out_valid_r <= 1'b0;
    end
  end

  // Registered flags
  always @(posedge core_clk) begin
    if (rst || in_master_reset) begin
      empty_indicator <= 1'b1;
      full_indicator <= 1'b0;
      half_full_indicator <= 1'b0;
      almost_empty_indicator <= 1'b1;
      almost_full_indicator <= 1'b0;
    end else begin
      empty_indicator <= fall_through_select_mode ? out_valid_r : !avail;
      full_indicator <= fall_through_select_mode ? fifo_in_ready : !fifo_in_ready;
      half_full_indicator <= (fifo_count > (DEPTH / 2));
      almost_empty_indicator <= (fifo_count < offset_empty_r);
      almost_full_indicator <= (free_count <= offset_full_r);
    end
  end
endmodule // fifo_port_config

//--- src/fifo_port_regs.vh
// Constants for the bus-matching FIFO port block: width codes, strap
// bit positions and default flag offsets.
// Included by fifo_port_config.v; definitions only.
`ifndef FIFO_PORT_REGS_VH
`define FIFO_PORT_REGS_VH

// Port width codes
`define PORT_W36 2'h0
`define PORT_W18 2'h1
`define PORT_W9 2'h2

// Piece widths in bits
`define PIECE_BITS_36 36
`define PIECE_BITS_18 18
`define PIECE_BITS_9 9

// Pieces per 36-bit word, minus one
`define LAST_PIECE_36 3'h0
`define LAST_PIECE_18 3'h1
`define LAST_PIECE_9 3'h3

// Latched configuration vector bit positions
`define CFG_BYTE_ORDER 0
`define CFG_FALL_THROUGH 1
`define CFG_PARITY 2
`define CFG_SERIAL 3
`define CFG_RD_WIDTH 4
`define CFG_WR_WIDTH 6
`define CFG_RESET 8'h00

// Default offsets, indexed by {load level, select 1, select 0}
`define DEF_OFS_0 8'h01
`define DEF_OFS_1 8'h02
`define DEF_OFS_2 8'h03
`define DEF_OFS_3 8'h04
`define DEF_OFS_4 8'h05
`define DEF_OFS_5 8'h06
`define DEF_OFS_6 8'h07
`define DEF_OFS_7 8'h08

`endif

//--- src/word_fifo.v
// Synchronous FIFO with parameterised width and depth, valid/ready on
// both sides and a synchronous flush.
// Assumes one clock; DEPTH is a power of two equal to 2**AW.
`timescale 1ns/1ps
module word_fifo #(
  parameter W = 36,
  parameter AW = 4,
  parameter DEPTH = 16
) (
  input wire clk,
  input wire rst,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data,
  output wire [AW:0] count
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_r;
  reg [AW:0] rd_ptr_r;
  wire push;
  wire pop;

  assign count = wr_ptr_r - rd_ptr_r;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (rst || flush) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // word_fifo

//--- verif/fifo_port_config_properties.sv
// Checker for fifo_port_config: reset outputs, flag relations, hold.
// Bound to the design top; sees its ports only.
`timescale 1ns/1ps
module fifo_port_config_properties (
  input wire core_clk,
  input wire rst,
  input wire master_reset_n,
  input wire fall_through_select,
  input wire read_en,
  input wire write_en,
  input wire [35:0] read_data_out,
  input wire empty_indicator,
  input wire full_indicator,
  input wire half_full_indicator
);
  reg ft_r;
  reg [1:0] up_r;
  wire run_w = up_r == 2'h3 && master_reset_n;
  wire std_w = run_w && !ft_r;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Own copy of timing mode, settle count
  always @(posedge core_clk) begin
    if (rst) ft_r <= 1'b0;
    else if (!master_reset_n) ft_r <= fall_through_select;
    if (rst || !master_reset_n) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  property p_rst_out;
    $fell(rst) |-> read_data_out == 36'h0 && empty_indicator && !full_indicator;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("bad outputs after reset");
  property p_mrs_out;
    $rose(master_reset_n) |-> read_data_out == 36'h0 && !half_full_indicator;
  endproperty
  a_mrs_out: assert property (p_mrs_out) else $error("bad outputs after master reset");
  property p_std_flags;
    std_w |-> !(empty_indicator && full_indicator);
  endproperty
  a_std_flags: assert property (p_std_flags) else $error("empty and full together");
  property p_ft_flags;
    run_w && ft_r |-> empty_indicator || full_indicator;
  endproperty
  a_ft_flags: assert property (p_ft_flags) else $error("no data and no space");
  property p_half;
    std_w && half_full_indicator |-> !empty_indicator;
  endproperty
  a_half: assert property (p_half) else $error("half full while empty");
  property p_hold;
    std_w && !read_en |=> $stable(read_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved without read");
  property p_rose_full;
    std_w && $rose(full_indicator) |-> $past(write_en) || $past(write_en, 2);
  endproperty
  a_rose_full: assert property (p_rose_full) else $error("full without write");
  property p_fell_empty;
    std_w && $fell(empty_indicator) |-> $past(write_en) || $past(write_en, 2);
  endproperty
  a_fell_empty: assert property (p_fell_empty) else $error("data without write");
endmodule // fifo_port_config_properties
bind fifo_port_config fifo_port_config_properties chk (.core_clk(core_clk), .rst(rst),
  .master_reset_n(master_reset_n), .fall_through_select(fall_through_select),
  .read_en(read_en), .write_en(write_en), .read_data_out(read_data_out),
  .empty_indicator(empty_indicator), .full_indicator(full_indicator),
  .half_full_indicator(half_full_indicator));

//--- verif/fifo_far_side.sv
// Reading party: pulls pieces while the FIFO shows readable data.
// Standard timing assumed; drives read_en on falling edges.
`timescale 1ns/1ps
module fifo_far_side (
  input wire core_clk,
  input wire pull,
  input wire empty_indicator,
  input wire [35:0] read_data_out,
  output reg read_en
);
  reg [35:0] got [$];
  initial begin
    read_en = 1'b0;
    forever begin
      @(negedge core_clk);
      if (pull && empty_indicator === 1'b0) begin
        read_en = 1'b1;
        @(negedge core_clk);
        read_en = 1'b0;
        got.push_back(read_data_out);
      end
    end
  end
endmodule // fifo_far_side

//--- verif/test_fifo_port_config.sv
// Testbench for fifo_port_config: straps, bus matching, flags, offsets.
// Reader is fifo_far_side; inputs change on falling edges.
`timescale 1ns/1ps
module test_fifo_port_config;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg master_reset_n = 1'b1;
  reg [8:0] strap = 9'h000;
  reg ft = 1'b0;
  reg ld = 1'b0;
  reg sen = 1'b0;
  reg we = 1'b0;
  reg [35:0] wd = 36'h0;
  reg tb_re = 1'b0;
  reg pull = 1'b0;
  wire p_re;
  wire [35:0] rd;
  wire ef, ff, hf, ae, af;
  integer n_errors = 0;
  integer checks_done = 0;
  localparam [35:0] W1 = 36'h9A5C3E1B7;
  localparam [35:0] W2 = 36'h2468ACE13;
  fifo_port_config uut (.core_clk(core_clk), .rst(rst), .master_reset_n(master_reset_n),
    .width_match_select(strap[8]), .write_width_select(strap[7]),
    .read_width_select(strap[6]), .byte_order_select(strap[5]),
    .parity_placement_select(strap[4]), .default_offset_select_0(strap[0]),
    .default_offset_select_1(strap[1]), .fall_through_select(ft),
    .offset_access_enable(ld), .serial_load_en(sen), .write_en(we),
    .write_data_in(wd), .read_en(p_re | tb_re), .read_data_out(rd),
    .empty_indicator(ef), .full_indicator(ff), .half_full_indicator(hf),
    .almost_empty_indicator(ae), .almost_full_indicator(af));
  fifo_far_side far (.core_clk(core_clk), .pull(pull), .empty_indicator(ef),
    .read_data_out(rd), .read_en(p_re));
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task end_of_test;
    begin
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input string nm, input [35:0] exp, input [35:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge core_clk);
  endtask
  function integer pw(input narrow, input nine);
    pw = narrow ? (nine ? 9 : 18) : 36;
  endfunction
  function [35:0] piece(input [35:0] w, input integer b, input integer i);
    piece = (w >> (strap[5] ? i * b : 36 - (i + 1) * b)) & ({36{1'b1}} >> (36 - b));
  endfunction
  task mreset(input [8:0] s);
    begin
      strap = s;
      ft = s[3];
      ld = s[2];
      master_reset_n = 1'b0;
      cyc(2);
      master_reset_n = 1'b1;
      ld = 1'b0;
      far.got.delete();
      cyc(3);
    end
  endtask
  task put(input [35:0] w);
    integer i, b;
    begin
      b = pw(strap[8] & strap[7], strap[6]);
      for (i = 0; i < 36 / b; i = i + 1) begin
        wd = piece(w, b, i) | ~({36{1'b1}} >> (36 - b));
        we = 1'b1;
        cyc(1);
      end
      we = 1'b0;
      cyc(1);
    end
  endtask
  task drain(input integer n);
    integer t;
    begin
      pull = 1'b1;
      for (t = 0; t < 400 && far.got.size() < n; t = t + 1) cyc(1);
      if (t == 400) begin
        chk("drain wait", 36'h1, 36'h0);
        end_of_test;
      end
      cyc(8);
      pull = 1'b0;
      chk("pieces", n, far.got.size());
    end
  endtask
  task rd_ofs(input [4:0] e, input [4:0] f);
    begin
      ld = 1'b1;
      tb_re = 1'b1;
      cyc(1);
      chk("empty ofs", e, rd[4:0]);
      cyc(1);
      tb_re = 1'b0;
      chk("full ofs", f, rd[4:0]);
      ld = 1'b0;
      cyc(1);
    end
  endtask
  task s_widths;
    integer c, k, b;
    reg [14:0] tab;
    begin
      tab = 15'b000_100_101_110_111;
      for (c = 0; c < 10; c = c + 1) begin
        mreset({tab[14 - 3 * (c / 2) -: 3], c[0], 5'h10});
        put(W1);
        put(W2);
        b = pw(strap[8] & !strap[7], strap[6]);
        drain(72 / b);
        for (k = 0; k < 72 / b; k = k + 1)
          chk("piece", piece(k < 36 / b ? W1 : W2, b, k % (36 / b)), far.got[k]);
      end
    end
  endtask
  task s_depth;
    integer i;
    begin
      mreset(9'h000);
      chk("almost full", 36'h0, af);
      for (i = 0; i < 17; i = i + 1) begin
        put(36'h100 + i);
        if (i == 7 || i == 8) begin
          cyc(3);
          chk("half", i == 8, hf);
        end
      end
      cyc(3);
      chk("full", 36'h1, ff);
      chk("empty", 36'h0, ef);
      chk("almost full", 36'h1, af);
      drain(16);
      chk("last", 36'h10F, far.got[15]);
      chk("empty", 36'h1, ef);
      chk("full", 36'h0, ff);
      chk("almost full", 36'h0, af);
      chk("almost empty", 36'h1, ae);
    end
  endtask
  task s_fall_through_select;
    begin
      mreset(9'h008);
      chk("out ready", 36'h0, ef);
      chk("in ready", 36'h1, ff);
      ft = 1'b0;
      put(W1);
      cyc(4);
      chk("out ready", 36'h1, ef);
      chk("fall data", W1, rd);
      chk("in ready", 36'h1, ff);
    end
  endtask
  task s_ofs;
    integer i;
    reg [9:0] sbits;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        mreset({6'h00, i[2:0]});
        rd_ofs(i + 1, i + 1);
      end
      sbits = 10'h185;
      ld = 1'b1;
      sen = 1'b1;
      for (i = 0; i < 10; i = i + 1) begin
        ft = sbits[i];
        cyc(1);
      end
      sen = 1'b0;
      rd_ofs(5'h05, 5'h0C);
      mreset(9'h000);
      ld = 1'b1;
      wd = 36'h3;
      we = 1'b1;
      cyc(1);
      wd = 36'h7;
      cyc(1);
      we = 1'b0;
      rd_ofs(5'h03, 5'h07);
      put(36'h1);
      put(36'h2);
      cyc(3);
      chk("almost empty", 36'h1, ae);
      put(36'h3);
      cyc(3);
      chk("almost empty", 36'h0, ae);
      chk("almost full", 36'h0, af);
      for (i = 4; i < 9; i = i + 1) put(i);
      cyc(3);
      chk("almost full", 36'h0, af);
      put(36'h9);
      cyc(3);
      chk("almost full", 36'h1, af);
    end
  endtask
  initial begin
    cyc(6);
    rst = 1'b0;
    cyc(2);
    chk("data", 36'h0, rd);
    chk("empty", 36'h1, ef);
    chk("half", 36'h0, hf);
    s_widths;
    s_depth;
    s_fall_through_select;
    s_ofs;
    end_of_test;
  end
endmodule // test_fifo_port_config
